// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tmb_pkg::*;
;
  localparam logic [7:0] A_CP = 8'h00;
  localparam logic [7:0] A_CS = 8'h04;
  localparam logic [7:0] A_EV = 8'h10;
  logic        i_clock, i_rst_n, psel, penable, pwrite, pready, pslverr, err, stby, lvl, sreq, zreq;
  logic        ev, ctick, srst, zrst, en, clr, ld, irq, wout, woe, orun;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, row;
  int          miscompares = 0, n_checks = 0, c_ld, c_clr, c_irq, c_en, first, t0;
  // {cp, cs, ev, stop first/standby/level, load/clear/irq}
  logic [31:0] rows [23] = '{32'h01000110, 32'h01071100, 32'h01020115, 32'h01021105, 32'h01020010,
    32'h01030100, 32'h01030117, 32'h01040105, 32'h01040112, 32'h01041102, 32'h01010152,
    32'h01010100, 32'h01011110, 32'h01011102, 32'h01050112, 32'h01050104, 32'h01050111,
    32'h01060100, 32'h01061112, 32'h00021100, 32'h01020130, 32'h41021125, 32'h01460152};
  logic [7:0]  adr [3] = '{A_CP, A_CS, A_EV};
  logic [7:0]  msk [3] = '{MASK_CONTROL_PRIMARY, MASK_CONTROL_SECONDARY, MASK_EVENT_CONTROL};
  logic [7:0]  rcp [5] = '{8'h01, 8'h03, 8'h05, 8'h0F, 8'h00};
  int          rexp [5] = '{20, 10, 5, 0, 0};

  tmb_timer_ctrl dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_standby(stby), .i_capture_event(ev),
    .i_count_event(ev), .i_companion_clock_en(ctick), .i_companion_restart(srst),
    .i_companion_zero_restart(zrst), .i_count_at_top(1'b0), .i_pwm_level(1'b0),
    .o_count_enable(en), .o_count_clear(clr), .o_capture_load(ld), .o_capture_irq(irq),
    .o_run(orun), .o_wave_out(wout), .o_wave_oe(woe));
  tmb_event_src model (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_level(lvl), .i_sel_req(sreq), .i_zero_req(zreq),
    .o_event(ev), .o_comp_tick(ctick), .o_sel_restart(srst), .o_zero_restart(zrst));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic cfg(input logic [7:0] cp, input logic [7:0] cs, input logic [7:0] ec);
    apb(1'b1, A_CS, {24'h0, cs});
    apb(1'b1, A_EV, {24'h0, ec});
    apb(1'b1, A_CP, {24'h0, cp});
  endtask

  task automatic obs(input int n);
    c_ld = 0;
    c_clr = 0;
    c_irq = 0;
    c_en = 0;
    first = -1;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clock);
      c_ld += int'(ld);
      c_clr += int'(clr);
      c_irq += int'(irq);
      c_en += int'(en);
      if (first < 0 && (ld | clr | irq) === 1'b1) first = k;
    end
  endtask

  task automatic pulse(input logic s, input logic z, input int exp);
    sreq <= s;
    zreq <= z;
    @(posedge i_clock);
    sreq <= 1'b0;
    zreq <= 1'b0;
    obs(6);
    chk("restart clear", exp, c_clr);
  endtask

  task automatic lat(input logic [7:0] cp, input logic [7:0] ec, input logic l);
    cfg(cp, 8'h02, ec);
    lvl <= l;
    obs(14);
  endtask

  initial begin
    #(25 * 20000);
    miscompares++;
    complete_run();
  end

  initial begin
    {i_rst_n, psel, penable, pwrite, stby, lvl, sreq, zreq} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    foreach (rows[i]) begin
      row = rows[i];
      stby <= row[5];
      // a stop first clears run, so start actions can show
      if (row[6]) apb(1'b1, A_CP, 32'h0);
      cfg(row[31:24], row[23:16], row[15:8]);
      lvl <= row[4];
      obs(14);
      chk("actions", {28'h0, row[3:0]}, 32'(c_ld * 4 + c_clr * 2 + c_irq));
    end
    chk("one-shot pin", 32'h1, {31'h0, wout});
    stby <= 1'b0;
    // reset in mid-run must restore the defaults
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    foreach (adr[i]) begin
      apb(1'b0, adr[i], 32'h0);
      chk("reset value", 32'h0, rd);
      apb(1'b1, adr[i], 32'hFFFFFFFF);
      apb(1'b0, adr[i], 32'h0);
      chk("writable bits", {24'h0, msk[i]}, rd);
    end
    apb(1'b1, 8'h08, 32'hFF);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped read", 32'h0, rd);
    cfg(8'h11, 8'h00, 8'h00);
    pulse(1'b0, 1'b1, 1);
    cfg(8'h15, 8'h00, 8'h00);
    pulse(1'b0, 1'b1, 0);
    pulse(1'b1, 1'b0, 1);
    cfg(8'h01, 8'h00, 8'h00);
    pulse(1'b1, 1'b1, 0);
    foreach (rcp[i]) begin
      cfg(rcp[i], 8'h00, 8'h00);
      obs(20);
      chk("count rate", rexp[i], c_en);
    end
    lvl <= 1'b0;
    cfg(8'h0F, 8'h00, 8'h00);
    t0 = 0;
    repeat (4) begin
      lvl <= ~lvl;
      obs(4);
      t0 += c_en;
    end
    chk("event count", 32'h2, t0);
    chk("run flag", 32'h1, {31'h0, orun});
    lat(8'h01, 8'h01, 1'b1);
    t0 = first;
    lat(8'h01, 8'h51, 1'b0);
    chk("filter delay", t0 + 4, first);
    lat(8'h21, 8'h01, 1'b1);
    chk("cascade delay", t0 + 1, first);
    cfg(8'h00, 8'h30, 8'h00);
    repeat (2) @(posedge i_clock);
    chk("pin drive", 32'h3, {30'h0, woe, wout});
    cfg(8'h00, 8'h20, 8'h00);
    repeat (2) @(posedge i_clock);
    chk("pin release", 32'h0, {31'h0, woe});
    complete_run();
  end
endmodule
`default_nettype wire

// file: test/tmb_event_src.sv
`timescale 1ns/1ps
`default_nettype none
module tmb_event_src (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // bench requests
  input  wire logic i_level,
  input  wire logic i_sel_req,
  input  wire logic i_zero_req,
  // event network and companion timer
  output logic      o_event,
  output logic      o_comp_tick,
  output logic      o_sel_restart,
  output logic      o_zero_restart
);
  logic [1:0] phase;

  // registered level, so no event is shorter than a clock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_event        <= 1'b0;
      o_sel_restart  <= 1'b0;
      o_zero_restart <= 1'b0;
      phase          <= 2'h0;
    end else begin
      o_event        <= i_level;
      o_sel_restart  <= i_sel_req;
      o_zero_restart <= i_zero_req;
      phase          <= phase + 2'h1;
    end
  end

  // companion ticks every fourth cycle
  assign o_comp_tick = (phase == 2'h3);
endmodule
`default_nettype wire

// file: verilog/tmb_clock_select.sv
`timescale 1ns/1ps
`default_nettype none
module tmb_clock_select
  import tmb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // selection
  input  wire logic       i_enable,
  input  wire logic [2:0] i_clock_source_select,
  // sources
  input  wire logic       i_companion_clock_en,
  input  wire logic       i_count_event,
  // count enable pulse
  output logic            o_tick
);
  logic half_phase;
  logic event_d;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_phase <= 1'b0;
    end else if (i_enable) begin
      half_phase <= ~half_phase;
    end else begin
      half_phase <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_d <= 1'b0;
    end else begin
      event_d <= i_count_event;
    end
  end

  // undefined codes give no count at all
  always_comb begin
    case (i_clock_source_select)
      CLK_UNDIVIDED: o_tick = i_enable; // [RQ6]
      CLK_HALF_RATE: o_tick = i_enable & half_phase; // [RQ6]
      CLK_COMPANION: o_tick = i_enable & i_companion_clock_en; // [RQ6]
      CLK_EVENT:     o_tick = i_enable & i_count_event & ~event_d; // [RQ6]
      default:       o_tick = 1'b0;
    endcase
  end

  AST_HALF_RATE: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RQ6]
    (i_clock_source_select == CLK_HALF_RATE && $stable(i_clock_source_select) && o_tick)
      |=> !o_tick)
    else $error("half rate ticked twice in a row");
endmodule
`default_nettype wire

// file: verilog/tmb_event_path.sv
`timescale 1ns/1ps
`default_nettype none
module tmb_event_path
  import tmb_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // configuration
  input  wire logic i_cascade,
  input  wire logic i_filter,
  // event in, edges out
  input  wire logic i_event,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_raw_rise,
  output logic      o_raw_fall
);
  logic                           sample;
  logic                           sample_d;
  logic                           level;
  logic                           level_d;
  logic [FILTER_DELAY_CYCLES-1:0] hist;
  logic                           src;

  assign src = i_cascade ? sample_d : sample; // [RQ3]

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample   <= 1'b0;
      sample_d <= 1'b0;
    end else begin
      sample   <= i_event;
      sample_d <= sample; // matches carry delay in a chained pair [RQ3]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist <= '0;
    end else begin
      hist <= {hist[FILTER_DELAY_CYCLES-2:0], src};
    end
  end

  // level moves only after five agreeing samples; runs on the undivided clock
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level   <= 1'b0;
      level_d <= 1'b0;
    end else begin
      if (!i_filter || hist == {FILTER_DELAY_CYCLES{src}}) begin
        level <= src; // [RQ12] [RQ13]
      end
      level_d <= level;
    end
  end

  assign o_rise     = level & ~level_d;
  assign o_fall     = ~level & level_d;
  assign o_raw_rise = i_event & ~sample;
  assign o_raw_fall = ~i_event & sample;

  AST_CASCADE_DELAY: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RQ3]
    (i_cascade && !i_filter && $stable(i_cascade) && $past(i_cascade) && !$past(i_filter))
      |-> level == $past(i_event, 3))
    else $error("cascade path delay wrong");

  AST_FILTER_DELAY: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RQ13]
    (i_filter && $past(i_filter) && $rose(level)) |-> ($past(src, 5) && $past(src, 2)))
    else $error("filtered level rose too early");
endmodule
`default_nettype wire

// file: verilog/tmb_pkg.sv
`default_nettype none
package tmb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL_PRIMARY   = 8'h00;
  localparam logic [7:0] IDX_CONTROL_SECONDARY = 8'h01;
  localparam logic [7:0] IDX_EVENT_CONTROL     = 8'h04;
  localparam logic [7:0] IDX_RUN_STATUS        = 8'h07;

  localparam logic [7:0] RST_CONTROL_PRIMARY   = 8'h00;
  localparam logic [7:0] RST_CONTROL_SECONDARY = 8'h00;
  localparam logic [7:0] RST_EVENT_CONTROL     = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_CONTROL_PRIMARY   = 8'h7F;
  localparam logic [7:0] MASK_CONTROL_SECONDARY = 8'h77;
  localparam logic [7:0] MASK_EVENT_CONTROL     = 8'h51;

  localparam int STANDBY_RUN_BIT  = 6;
  localparam int CASCADE_BIT      = 5;
  localparam int RESTART_SYNC_BIT = 4;
  localparam int CLOCK_SOURCE_SELECT_MSB       = 3;
  localparam int CLOCK_SOURCE_SELECT_LSB       = 1;
  localparam int ENABLE_BIT       = 0;
  localparam int IMMEDIATE_BIT    = 6;
  localparam int PIN_INIT_BIT     = 5;
  localparam int PIN_ENABLE_BIT   = 4;
  localparam int MODE_MSB         = 2;
  localparam int MODE_LSB         = 0;
  localparam int FILTER_BIT       = 6;
  localparam int EDGE_BIT         = 4;
  localparam int SNAPSHOT_EVENT_INPUT_ENABLE_BIT       = 0;
  localparam int RUN_BIT          = 0;

  localparam logic [2:0] CLK_UNDIVIDED = 3'h0;
  localparam logic [2:0] CLK_HALF_RATE = 3'h1;
  localparam logic [2:0] CLK_COMPANION = 3'h2;
  localparam logic [2:0] CLK_EVENT     = 3'h7;

  localparam logic [2:0] MODE_PERIODIC   = 3'h0;
  localparam logic [2:0] MODE_WINDOW     = 3'h1;
  localparam logic [2:0] MODE_SNAPSHOT   = 3'h2;
  localparam logic [2:0] MODE_FREQUENCY  = 3'h3;
  localparam logic [2:0] MODE_PULSE      = 3'h4;
  localparam logic [2:0] MODE_FREQ_PULSE = 3'h5;
  localparam logic [2:0] MODE_ONE_SHOT   = 3'h6;
  localparam logic [2:0] MODE_WAVEFORM8  = 3'h7;

  localparam int FILTER_DELAY_CYCLES = 4;

  typedef enum logic [1:0] {FP_WAIT_FIRST, FP_FIRST_PHASE, FP_SECOND_PHASE} tmb_fp_state_t;

  function automatic logic [7:0] reg_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  function automatic logic pick_edge(input logic edge_sel, input logic rise, input logic fall);
    return edge_sel ? fall : rise;
  endfunction
endpackage
`default_nettype wire

// file: verilog/tmb_timer_ctrl.sv
// Contract
// RQ1: standby-run bit keeps timer going in standby; otherwise it halts.
// RQ2: cascade bit enables chaining two timers for 32-bit counting; set on upper half.
// RQ3: cascade bit delays the capture event by one clock.
// RQ4: restart-sync bit restarts counter when companion timer restarts or overflows.
// RQ5: restart source is selected companion timer, else companion timer zero.
// RQ6: clock select picks undivided, half rate, companion clock or event edges.
// RQ7: timer runs only while the enable bit is one.
// RQ8: one-shot output rises at synced start, or at once with immediate bit.
// RQ9: pin initial level sets idle pin level, not in waveform or one-shot.
// RQ10: pin enable lets the waveform drive the pin; clear leaves it undriven.
// RQ11: mode field selects one of eight counting modes.
// RQ12: filter bit switches on the capture input noise canceller.
// RQ13: noise canceller adds four clock delay, independent of prescaler.
// RQ14: periodic and 8-bit waveform modes ignore capture events.
// RQ15: window check: selected edge starts counter, the other stops it.
// RQ16: snapshot mode captures count and interrupts on the selected edge.
// RQ17: frequency mode: selected edge captures, clears, restarts, interrupts.
// RQ18: pulse mode: one edge clears and restarts, the other captures and interrupts.
// RQ19: combined mode: clear, capture, then stop and interrupt on edge sequence.
// RQ20: one-shot: positive edge starts; either edge when edge-select is one.
// RQ21: capture events act only while snapshot input enable is set.
// RQ22: event source holds each event at least one clock, except immediate one-shot.
`timescale 1ns/1ps
`default_nettype none
module tmb_timer_ctrl
  import tmb_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // power state
  input  wire logic        i_standby,
  // event network
  input  wire logic        i_capture_event,
  input  wire logic        i_count_event,
  // companion timer
  input  wire logic        i_companion_clock_en,
  input  wire logic        i_companion_restart,
  input  wire logic        i_companion_zero_restart,
  // counter datapath
  input  wire logic        i_count_at_top,
  input  wire logic        i_pwm_level,
  output logic             o_count_enable,
  output logic             o_count_clear,
  output logic             o_capture_load,
  output logic             o_capture_irq,
  output logic             o_run,
  // waveform pin
  output logic             o_wave_out,
  output logic             o_wave_oe
);
  logic [7:0]    control_primary;
  logic [7:0]    control_secondary;
  logic [7:0]    event_control;
  tmb_fp_state_t fp_state;
  logic          run;
  logic          shot_level;
  logic          idle_level;
  logic          tick;
  logic          ev_rise;
  logic          ev_fall;
  logic          raw_rise;
  logic          raw_fall;

  logic          enable;
  logic          awake;
  logic          active;
  logic          events_ok;
  logic [2:0]    mode;
  logic [2:0]    clock_source_select;
  logic          edge_sel;
  logic          sel_edge;
  logic          other_edge;
  logic          shot_trigger;
  logic          raw_trigger;
  logic          restart_src;
  logic          next_load;
  logic          next_clear;
  logic          next_irq;

  assign enable              = control_primary[ENABLE_BIT];
  assign clock_source_select = control_primary[CLOCK_SOURCE_SELECT_MSB:CLOCK_SOURCE_SELECT_LSB];
  assign mode                = control_secondary[MODE_MSB:MODE_LSB]; // [RQ11]
  assign edge_sel            = event_control[EDGE_BIT];
  assign awake  = ~i_standby | control_primary[STANDBY_RUN_BIT]; // [RQ1]
  assign active = enable & awake; // [RQ7]
  // events are ignored in modes that have no event action
  assign events_ok = active & event_control[SNAPSHOT_EVENT_INPUT_ENABLE_BIT] // [RQ21]
                     & (mode != MODE_PERIODIC) & (mode != MODE_WAVEFORM8); // [RQ14]
  assign sel_edge   = pick_edge(edge_sel, ev_rise, ev_fall);
  assign other_edge = pick_edge(edge_sel, ev_fall, ev_rise);
  assign shot_trigger = edge_sel ? (ev_rise | ev_fall) : ev_rise; // [RQ20]
  assign raw_trigger  = edge_sel ? (raw_rise | raw_fall) : raw_rise; // [RQ22]
  assign restart_src = (clock_source_select == CLK_COMPANION) ? i_companion_restart
                                                                : i_companion_zero_restart; // [RQ5]

  // upper half of a chained pair only differs by the event delay [RQ2]
  tmb_event_path u_event_path (
    .i_clock    (i_clock),
    .i_rst_n    (i_rst_n),
    .i_cascade  (control_primary[CASCADE_BIT]),
    .i_filter   (event_control[FILTER_BIT]),
    .i_event    (i_capture_event),
    .o_rise     (ev_rise),
    .o_fall     (ev_fall),
    .o_raw_rise (raw_rise),
    .o_raw_fall (raw_fall)
  );

  tmb_clock_select u_clock_select (
    .i_clock               (i_clock),
    .i_rst_n               (i_rst_n),
    .i_enable              (active),
    .i_clock_source_select (clock_source_select),
    .i_companion_clock_en  (i_companion_clock_en),
    .i_count_event         (i_count_event),
    .o_tick                (tick)
  );

  // apb: zero wait states, read data and error latched in the setup cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= 1'b1;
      if (i_psel && !i_penable) begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h0000_0000;
        if (i_paddr == reg_addr(IDX_CONTROL_PRIMARY)) begin
          o_prdata[7:0] <= control_primary;
        end else if (i_paddr == reg_addr(IDX_CONTROL_SECONDARY)) begin
          o_prdata[7:0] <= control_secondary;
        end else if (i_paddr == reg_addr(IDX_EVENT_CONTROL)) begin
          o_prdata[7:0] <= event_control;
        end else if (i_paddr == reg_addr(IDX_RUN_STATUS)) begin
          o_prdata[RUN_BIT] <= run;
          o_pslverr         <= i_pwrite;
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control_primary   <= RST_CONTROL_PRIMARY;
      control_secondary <= RST_CONTROL_SECONDARY;
      event_control     <= RST_EVENT_CONTROL;
    end else if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == reg_addr(IDX_CONTROL_PRIMARY)) begin
        control_primary <= i_pwdata[7:0] & MASK_CONTROL_PRIMARY;
      end else if (i_paddr == reg_addr(IDX_CONTROL_SECONDARY)) begin
        control_secondary <= i_pwdata[7:0] & MASK_CONTROL_SECONDARY;
      end else if (i_paddr == reg_addr(IDX_EVENT_CONTROL)) begin
        event_control <= i_pwdata[7:0] & MASK_EVENT_CONTROL;
      end
    end
  end

  // per-mode event actions
  always_comb begin
    next_load  = 1'b0;
    next_clear = 1'b0;
    next_irq   = 1'b0;
    if (events_ok) begin
      case (mode)
        MODE_SNAPSHOT: begin
          next_load = sel_edge; // [RQ16]
          next_irq  = sel_edge; // [RQ16]
        end
        MODE_FREQUENCY: begin
          next_load  = sel_edge; // [RQ17]
          next_clear = sel_edge; // [RQ17]
          next_irq   = sel_edge; // [RQ17]
        end
        MODE_PULSE: begin
          next_clear = sel_edge; // [RQ18]
          next_load  = other_edge; // [RQ18]
          next_irq   = other_edge; // [RQ18]
        end
        MODE_FREQ_PULSE: begin
          case (fp_state)
            FP_WAIT_FIRST:   next_clear = sel_edge; // [RQ19]
            FP_FIRST_PHASE:  next_load  = other_edge; // [RQ19]
            FP_SECOND_PHASE: next_irq   = sel_edge; // [RQ19]
            default:         next_irq   = 1'b0;
          endcase
        end
        MODE_WINDOW: next_clear = sel_edge & ~run;
        MODE_ONE_SHOT: next_clear = shot_trigger & ~run;
        default: next_load = 1'b0;
      endcase
    end
    if (active && control_primary[RESTART_SYNC_BIT] && restart_src) begin
      next_clear = 1'b1; // [RQ4]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fp_state <= FP_WAIT_FIRST;
    end else if (!active || mode != MODE_FREQ_PULSE) begin
      fp_state <= FP_WAIT_FIRST;
    end else if (events_ok) begin
      case (fp_state)
        FP_WAIT_FIRST: begin
          if (sel_edge) begin
            fp_state <= FP_FIRST_PHASE;
          end
        end
        FP_FIRST_PHASE: begin
          if (other_edge) begin
            fp_state <= FP_SECOND_PHASE;
          end
        end
        default: begin
          if (sel_edge) begin
            fp_state <= FP_WAIT_FIRST;
          end
        end
      endcase
    end
  end

  // run state; disabling or entering standby-halt drops it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run <= 1'b0;
    end else if (!active) begin
      run <= 1'b0;
    end else begin
      case (mode)
        MODE_WINDOW: begin
          if (events_ok && sel_edge) begin
            run <= 1'b1; // [RQ15]
          end else if (events_ok && other_edge) begin
            run <= 1'b0; // [RQ15]
          end
        end
        MODE_FREQ_PULSE: begin
          if (events_ok && fp_state == FP_WAIT_FIRST && sel_edge) begin
            run <= 1'b1;
          end else if (events_ok && fp_state == FP_SECOND_PHASE && sel_edge) begin
            run <= 1'b0; // [RQ19]
          end
        end
        MODE_ONE_SHOT: begin
          if (events_ok && shot_trigger && !run) begin
            run <= 1'b1; // [RQ20]
          end else if (run && i_count_at_top) begin
            run <= 1'b0;
          end
        end
        default: run <= 1'b1;
      endcase
    end
  end

  // one-shot pin: immediate mode reacts to the unsynchronised edge, two cycles early with neither cascade nor filter set
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shot_level <= 1'b0;
    end else if (!active || mode != MODE_ONE_SHOT) begin
      shot_level <= 1'b0;
    end else if (control_secondary[IMMEDIATE_BIT] && events_ok && raw_trigger) begin
      shot_level <= 1'b1; // [RQ8]
    end else if (events_ok && shot_trigger && !run) begin
      shot_level <= 1'b1; // [RQ8]
    end else if (run && i_count_at_top) begin
      shot_level <= 1'b0;
    end
  end

  // idle pin level is loaded only while the timer is off
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_level <= 1'b0;
    end else if (!enable) begin
      idle_level <= control_secondary[PIN_INIT_BIT]; // [RQ9]
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wave_out <= 1'b0;
      o_wave_oe  <= 1'b0;
    end else begin
      o_wave_oe <= control_secondary[PIN_ENABLE_BIT]; // [RQ10]
      if (mode == MODE_ONE_SHOT) begin
        o_wave_out <= shot_level;
      end else if (mode == MODE_WAVEFORM8) begin
        o_wave_out <= i_pwm_level;
      end else begin
        o_wave_out <= idle_level; // [RQ9]
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count_enable <= 1'b0;
      o_count_clear  <= 1'b0;
      o_capture_load <= 1'b0;
      o_capture_irq  <= 1'b0;
      o_run          <= 1'b0;
    end else begin
      o_count_enable <= active & run & tick; // [RQ1] [RQ7]
      o_count_clear  <= next_clear;
      o_capture_load <= next_load;
      o_capture_irq  <= next_irq;
      o_run          <= run;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_fp_first;
    events_ok && mode == MODE_FREQ_PULSE && fp_state == FP_WAIT_FIRST && sel_edge;
  endsequence
  sequence s_fp_capture;
    events_ok && mode == MODE_FREQ_PULSE && fp_state == FP_FIRST_PHASE && other_edge;
  endsequence

  AST_STANDBY_HALT: assert property ((i_standby && !control_primary[STANDBY_RUN_BIT]) // [RQ1]
    |=> !o_count_enable && !o_capture_load)
    else $error("counting during standby halt");
  AST_DISABLED_IDLE: assert property (!enable |=> !o_count_enable && !o_capture_irq ##1 !o_run) // [RQ7]
    else $error("activity while disabled");
  AST_IGNORED_MODES: assert property ((mode == MODE_PERIODIC || mode == MODE_WAVEFORM8) // [RQ14]
    |=> !o_capture_load && !o_capture_irq)
    else $error("capture in a mode without events");
  AST_INPUT_GATE: assert property (!event_control[SNAPSHOT_EVENT_INPUT_ENABLE_BIT] |=> !o_capture_load && !o_capture_irq) // [RQ21]
    else $error("capture with event input disabled");
  AST_SNAPSHOT: assert property ((events_ok && mode == MODE_SNAPSHOT && sel_edge) // [RQ16]
    |=> o_capture_load && o_capture_irq)
    else $error("snapshot edge not captured");
  AST_FREQUENCY: assert property ((events_ok && mode == MODE_FREQUENCY && other_edge) // [RQ17]
    |=> !o_capture_load && !o_capture_irq)
    else $error("frequency mode acted on wrong edge");
  AST_PULSE: assert property ((events_ok && mode == MODE_PULSE && sel_edge) // [RQ18]
    |=> o_count_clear && !o_capture_load)
    else $error("pulse mode restart edge wrong");
  AST_FREQ_PULSE: assert property (s_fp_first ##[1:100] s_fp_capture |=> o_capture_load && !o_capture_irq) // [RQ19]
    else $error("combined mode capture step wrong");
  AST_SYNC_RESTART: assert property ((active && control_primary[RESTART_SYNC_BIT] // [RQ5]
    && clock_source_select == CLK_UNDIVIDED && i_companion_zero_restart) |=> o_count_clear)
    else $error("restart from companion zero missed");
  AST_IMMEDIATE_SHOT: assert property ((events_ok && mode == MODE_ONE_SHOT && !run // [RQ8]
    && !shot_level && control_secondary[IMMEDIATE_BIT] && raw_trigger) |=> shot_level ##1 o_wave_out)
    else $error("immediate one-shot output late");
  AST_WINDOW_STOP: assert property ((events_ok && mode == MODE_WINDOW && other_edge && !sel_edge) // [RQ15]
    |=> !run)
    else $error("window check did not stop");
endmodule
`default_nettype wire
